/* design/smc_cfg.svh */
`ifndef SMC_CFG_SVH
`define SMC_CFG_SVH
`define SMC_ADDR_W 12
`define SMC_IDX_W 10
`define SMC_POWER_CONTROL_IDX 10'h087
`define SMC_STAT_IDX 10'h088
`define SMC_POWER_CONTROL_RST 8'h00
`define SMC_POWER_CONTROL_WMASK 8'hdf
`define SMC_BIT_LIGHT 0
`define SMC_BIT_DEEP 1
`define SMC_STAT_ID_LSB 4
`define SMC_STAT_RST_BIT 8
`define SMC_DEEP_WAKE_MASK 8'h3f
`define SMC_ID_W 3
`define SMC_RESP_OKAY 2'b00
`define SMC_RESP_SLVERR 2'b10
`endif

/* design/smc_pkg.sv */
package smc_pkg;
  typedef enum logic [1:0] {SMC_RUN, SMC_LIGHT, SMC_DEEP, SMC_OSC_WAIT} smc_state_t;
endpackage

/* design/smc_wake_if.sv */
`timescale 1ns/10ps
`include "smc_cfg.svh"
interface smc_wake_if;
  logic light_wake;
  logic deep_wake;
  logic [`SMC_ID_W-1:0] wake_id;
  logic reset_hit;
  logic osc_stable;
  modport filt (output light_wake, output deep_wake, output wake_id, output reset_hit,
    output osc_stable);
  modport ctrl (input light_wake, input deep_wake, input wake_id, input reset_hit,
    input osc_stable);
endinterface

/* design/smc_wake_filter.sv */
`timescale 1ns/10ps
`include "smc_cfg.svh"
module smc_wake_filter
#(
  parameter int N_IRQ = 8,
  parameter int N_RST = 4
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [N_IRQ-1:0] irq_req,
  input wire logic [N_IRQ-1:0] irq_en,
  input wire logic [N_RST-1:0] reset_src,
  input wire logic osc_stable,
  smc_wake_if.filt w
);
  localparam logic [7:0] DEEP_MASK = `SMC_DEEP_WAKE_MASK;
  logic [N_IRQ-1:0] irq_s1, irq_s2, next_irq_s1, next_irq_s2;
  logic [N_RST-1:0] rst_s1, rst_s2, next_rst_s1, next_rst_s2;
  logic osc_s1, osc_s2, next_osc_s1, next_osc_s2;
  logic [N_IRQ-1:0] pend;
  logic [N_IRQ-1:0] deep_ok;
  logic [`SMC_ID_W-1:0] id;

  if (N_IRQ < 6 || N_IRQ > 8)
  begin : g_bad_irq
    $error("N_IRQ must lie between 6 and 8");
  end
  if (N_RST < 1)
  begin : g_bad_rst
    $error("N_RST must be at least 1");
  end

  always_comb
  begin
    next_irq_s1 = irq_req;
    next_irq_s2 = irq_s1;
    next_rst_s1 = reset_src;
    next_rst_s2 = rst_s1;
    next_osc_s1 = osc_stable;
    next_osc_s2 = osc_s1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_s1 <= '0;
      irq_s2 <= '0;
      rst_s1 <= '0;
      rst_s2 <= '0;
      osc_s1 <= 1'b0;
      osc_s2 <= 1'b0;
    end
    else
    begin
      irq_s1 <= next_irq_s1;
      irq_s2 <= next_irq_s2;
      rst_s1 <= next_rst_s1;
      rst_s2 <= next_rst_s2;
      osc_s1 <= next_osc_s1;
      osc_s2 <= next_osc_s2;
    end
  end

  genvar i;
  for (i = 0; i < N_IRQ; i++)
  begin : g_src
    assign pend[i] = irq_s2[i] & irq_en[i];
    assign deep_ok[i] = pend[i] & DEEP_MASK[i];
  end

  // lowest index wins, so the external pins outrank the rest
  always_comb
  begin
    id = '0;
    for (int k = N_IRQ - 1; k >= 0; k--)
    begin
      if (pend[k])
      begin
        id = k[`SMC_ID_W-1:0];
      end
    end
  end

  assign w.light_wake = |pend;
  assign w.deep_wake = |deep_ok;
  assign w.wake_id = id;
  assign w.reset_hit = |rst_s2;
  assign w.osc_stable = osc_s2;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  AST_FILT_MASK: assert property (w.deep_wake |-> DEEP_MASK[w.wake_id] && pend[w.wake_id])
    else $error("deep wake raised by a source that may not wake");
endmodule

/* design/sleep_mode_controller.sv */
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "smc_cfg.svh"
module sleep_mode_controller
#(
  parameter int N_IRQ = 8,
  parameter int N_RST = 4
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`SMC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`SMC_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [N_IRQ-1:0] irq_req,
  input wire logic [N_IRQ-1:0] irq_en,
  input wire logic [N_RST-1:0] reset_src,
  input wire logic osc_stable,
  output smc_pkg::smc_state_t power_state,
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic fetch_hold,
  output logic port_hold,
  output logic osc_enable,
  output logic flash_stop,
  output logic ram_retain,
  output logic wake_irq,
  output logic [`SMC_ID_W-1:0] wake_irq_id,
  output logic cpu_restart
);
  import smc_pkg::*;

  smc_wake_if wk();

  smc_wake_filter #(.N_IRQ(N_IRQ), .N_RST(N_RST)) u_filt
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .irq_req(irq_req),
    .irq_en(irq_en),
    .reset_src(reset_src),
    .osc_stable(osc_stable),
    .w(wk.filt)
  );

  // bus slave: one write and one read in flight at most
  logic aw_held, next_aw_held, w_held, next_w_held;
  logic [`SMC_IDX_W-1:0] aw_idx, next_aw_idx;
  logic [7:0] wbyte, next_wbyte;
  logic wlane, next_wlane;
  logic bvalid, next_bvalid;
  logic [1:0] bresp, next_bresp;
  logic rvalid, next_rvalid;
  logic [1:0] rresp, next_rresp;
  logic [31:0] rdata, next_rdata;
  logic wr_fire;
  logic wr_power_control;
  logic [`SMC_IDX_W-1:0] ar_idx;

  assign s_axi_awready = !aw_held && !bvalid;
  assign s_axi_wready = !w_held && !bvalid;
  assign s_axi_arready = !rvalid;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rresp = rresp;
  assign s_axi_rdata = rdata;
  assign ar_idx = s_axi_araddr[`SMC_ADDR_W-1:2];
  assign wr_fire = aw_held && w_held && !bvalid;

  // control state
  smc_state_t state, next_state;
  logic [7:0] power_control, next_power_control;
  logic [`SMC_ID_W-1:0] last_id, next_last_id;
  logic rst_woke, next_rst_woke;
  logic next_wake_irq, next_cpu_restart;
  // sleep requests only count while the core runs; a stopped core writes nothing
  assign wr_power_control = wr_fire && wlane && aw_idx == `SMC_POWER_CONTROL_IDX && state == SMC_RUN;

  always_comb
  begin
    next_aw_held = aw_held;
    next_aw_idx = aw_idx;
    next_w_held = w_held;
    next_wbyte = wbyte;
    next_wlane = wlane;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rresp = rresp;
    next_rdata = rdata;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_aw_held = 1'b1;
      next_aw_idx = s_axi_awaddr[`SMC_ADDR_W-1:2];
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_w_held = 1'b1;
      next_wbyte = s_axi_wdata[7:0];
      next_wlane = s_axi_wstrb[0];
    end
    if (wr_fire)
    begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      if (aw_idx == `SMC_POWER_CONTROL_IDX || aw_idx == `SMC_STAT_IDX)
      begin
        next_bresp = `SMC_RESP_OKAY;
      end
      else
      begin
        next_bresp = `SMC_RESP_SLVERR;
      end
    end
    else if (bvalid && s_axi_bready)
    begin
      next_bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_rvalid = 1'b1;
      next_rresp = `SMC_RESP_OKAY;
      next_rdata = '0;
      if (ar_idx == `SMC_POWER_CONTROL_IDX)
      begin
        next_rdata[7:0] = power_control;
      end
      else if (ar_idx == `SMC_STAT_IDX)
      begin
        next_rdata[1:0] = state;
        next_rdata[`SMC_STAT_ID_LSB +: `SMC_ID_W] = last_id;
        next_rdata[`SMC_STAT_RST_BIT] = rst_woke;
      end
      else
      begin
        next_rresp = `SMC_RESP_SLVERR;
      end
    end
    else if (rvalid && s_axi_rready)
    begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      aw_idx <= '0;
      w_held <= 1'b0;
      wbyte <= 8'h00;
      wlane <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `SMC_RESP_OKAY;
      rvalid <= 1'b0;
      rresp <= `SMC_RESP_OKAY;
      rdata <= 32'h0000_0000;
    end
    else
    begin
      aw_held <= next_aw_held;
      aw_idx <= next_aw_idx;
      w_held <= next_w_held;
      wbyte <= next_wbyte;
      wlane <= next_wlane;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
    end
  end

  always_comb
  begin
    next_state = state;
    next_power_control = power_control;
    next_last_id = last_id;
    next_rst_woke = rst_woke;
    next_wake_irq = 1'b0;
    next_cpu_restart = 1'b0;
    unique case (state)
      SMC_RUN:
      begin
        if (wr_power_control)
        begin
          next_power_control = wbyte & `SMC_POWER_CONTROL_WMASK;
        end
        // deep outranks light when both are requested
        if (next_power_control[`SMC_BIT_DEEP])
        begin
          next_state = SMC_DEEP;
        end
        else if (next_power_control[`SMC_BIT_LIGHT])
        begin
          next_state = SMC_LIGHT;
        end
      end
      SMC_LIGHT:
      begin
        if (wk.reset_hit)
        begin
          next_state = SMC_RUN;
          next_power_control[`SMC_BIT_LIGHT] = 1'b0;
          next_rst_woke = 1'b1;
          next_cpu_restart = 1'b1;
        end
        else if (wk.light_wake)
        begin
          next_state = SMC_RUN;
          next_power_control[`SMC_BIT_LIGHT] = 1'b0;
          next_last_id = wk.wake_id;
          next_rst_woke = 1'b0;
          next_wake_irq = 1'b1;
        end
      end
      SMC_DEEP:
      begin
        // brown-out reset only arrives if software armed the detector
        if (wk.reset_hit)
        begin
          next_state = SMC_RUN;
          next_power_control[`SMC_BIT_DEEP] = 1'b0;
          next_power_control[`SMC_BIT_LIGHT] = 1'b0;
          next_rst_woke = 1'b1;
          next_cpu_restart = 1'b1;
        end
        else if (wk.deep_wake)
        begin
          next_state = SMC_OSC_WAIT;
          next_power_control[`SMC_BIT_DEEP] = 1'b0;
          next_power_control[`SMC_BIT_LIGHT] = 1'b0;
          next_last_id = wk.wake_id;
          next_rst_woke = 1'b0;
        end
      end
      SMC_OSC_WAIT:
      begin
        if (wk.reset_hit)
        begin
          next_state = SMC_RUN;
          next_rst_woke = 1'b1;
          next_cpu_restart = 1'b1;
        end
        else if (wk.osc_stable)
        begin
          next_state = SMC_RUN;
          next_wake_irq = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= SMC_RUN;
      power_control <= `SMC_POWER_CONTROL_RST;
      last_id <= '0;
      rst_woke <= 1'b0;
      wake_irq <= 1'b0;
      cpu_restart <= 1'b0;
      cpu_clk_en <= 1'b1;
      periph_clk_en <= 1'b1;
      fetch_hold <= 1'b0;
      port_hold <= 1'b0;
      osc_enable <= 1'b1;
      flash_stop <= 1'b0;
      ram_retain <= 1'b0;
      wake_irq_id <= '0;
    end
    else
    begin
      state <= next_state;
      power_control <= next_power_control;
      last_id <= next_last_id;
      rst_woke <= next_rst_woke;
      wake_irq <= next_wake_irq;
      cpu_restart <= next_cpu_restart;
      cpu_clk_en <= next_state == SMC_RUN;
      periph_clk_en <= next_state == SMC_RUN || next_state == SMC_LIGHT;
      fetch_hold <= next_state != SMC_RUN;
      port_hold <= next_state != SMC_RUN;
      osc_enable <= next_state != SMC_DEEP;
      flash_stop <= next_state == SMC_DEEP || next_state == SMC_OSC_WAIT;
      ram_retain <= next_state == SMC_DEEP || next_state == SMC_OSC_WAIT;
      wake_irq_id <= next_last_id;
    end
  end

  assign power_state = state;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  AST_DEEP_CLOCKS: assert property (state == SMC_DEEP |-> !cpu_clk_en && !periph_clk_en)
    else $error("clocks running in deep sleep");
  AST_LIGHT_PERIPH: assert property (state == SMC_LIGHT |-> !cpu_clk_en && periph_clk_en)
    else $error("light sleep clock gating wrong");
  AST_DEEP_WAKE: assert property (state == SMC_DEEP && wk.deep_wake && !wk.reset_hit
    |=> state == SMC_OSC_WAIT && !power_control[`SMC_BIT_DEEP] && wake_irq_id == $past(wk.wake_id))
    else $error("deep wake did not clear request or keep source");
  AST_LIGHT_WAKE: assert property (state == SMC_LIGHT && wk.light_wake && !wk.reset_hit
    |=> state == SMC_RUN && wake_irq && !power_control[`SMC_BIT_LIGHT])
    else $error("light sleep not left on enabled interrupt");
  AST_BOTH_DEEP: assert property (wr_power_control && wbyte[1:0] == 2'b11
    |=> state == SMC_DEEP ##1 (state != SMC_LIGHT) [*8])
    else $error("both requests did not give deep sleep only");
  AST_ENTRY_WRITE: assert property (state == SMC_RUN && !wr_power_control |=> state == SMC_RUN)
    else $error("sleep entered without a request write");
  AST_LIGHT_HOLD: assert property (state == SMC_LIGHT |-> fetch_hold && port_hold)
    else $error("fetch or pins not held in light sleep");
  AST_RESUME: assert property (wake_irq |-> !cpu_restart && cpu_clk_en && !fetch_hold)
    else $error("wake interrupt with restart or stopped core");
  AST_RESET_END: assert property ((state == SMC_LIGHT || state == SMC_DEEP) && wk.reset_hit
    |=> state == SMC_RUN && cpu_restart ##1 !cpu_restart)
    else $error("reset did not end sleep with one restart pulse");
  AST_DEEP_FLASH: assert property (state == SMC_DEEP
    |-> flash_stop && ram_retain && port_hold)
    else $error("flash, ram or pins not held in deep sleep");
  AST_OSC_WAIT: assert property (state == SMC_OSC_WAIT && !wk.osc_stable && !wk.reset_hit
    |=> state == SMC_OSC_WAIT && osc_enable && !wake_irq)
    else $error("handler started before oscillator stable");
  AST_NO_WAKE: assert property (state == SMC_DEEP && !wk.deep_wake && !wk.reset_hit
    |=> state == SMC_DEEP && $stable(power_control))
    else $error("deep sleep left without permitted cause");
endmodule

/* verif/smc_cpu_model.sv */
`timescale 1ns/10ps
module smc_cpu_model
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic osc_enable,
  input wire logic cpu_clk_en,
  input wire logic cpu_restart,
  input wire logic [3:0] osc_dly,
  output logic osc_stable,
  output logic [7:0] pc
);
  logic [3:0] warm;
  // oscillator warms up osc_dly+1 cycles after enable; slow setting stresses the wait
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !osc_enable)
    begin
      warm <= 4'h0;
      osc_stable <= 1'b0;
    end
    else if (warm < osc_dly)
      warm <= warm + 4'h1;
    else
      osc_stable <= 1'b1;
  end
  // program counter only moves while the cpu clock runs
  always_ff @(posedge aclk)
  begin
    if (!aresetn || cpu_restart)
      pc <= 8'h00;
    else if (cpu_clk_en)
      pc <= pc + 8'h01;
  end
endmodule

/* verif/sleep_mode_controller_bench.sv */
`timescale 1ns/10ps
`include "smc_cfg.svh"
module sleep_mode_controller_bench;
  import smc_pkg::*;
  localparam logic [11:0] PC_A = {`SMC_POWER_CONTROL_IDX, 2'b00};
  localparam logic [11:0] ST_A = {`SMC_STAT_IDX, 2'b00};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h1;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [7:0] irq_req = 8'h00;
  logic [7:0] irq_en = 8'h00;
  logic [3:0] reset_src = 4'h0;
  logic [3:0] osc_dly = 4'h1;
  logic awready, wready, bvalid, arready, rvalid, osc_stable, clk_at_b;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  smc_state_t power_state;
  logic cpu_clk_en, periph_clk_en, fetch_hold, port_hold, osc_enable;
  logic flash_stop, ram_retain, wake_irq, cpu_restart;
  logic [2:0] wake_irq_id;
  logic [7:0] pc;
  int fails = 0;
  int n_compared = 0;
  int cycles = 0;

  sleep_mode_controller uut
  (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .irq_req(irq_req), .irq_en(irq_en), .reset_src(reset_src), .osc_stable(osc_stable),
    .power_state(power_state), .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
    .fetch_hold(fetch_hold), .port_hold(port_hold), .osc_enable(osc_enable),
    .flash_stop(flash_stop), .ram_retain(ram_retain), .wake_irq(wake_irq),
    .wake_irq_id(wake_irq_id), .cpu_restart(cpu_restart)
  );

  smc_cpu_model model
  (
    .aclk(aclk), .aresetn(aresetn), .osc_enable(osc_enable), .cpu_clk_en(cpu_clk_en),
    .cpu_restart(cpu_restart), .osc_dly(osc_dly), .osc_stable(osc_stable), .pc(pc)
  );

  always #5 aclk = ~aclk;

  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge aclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      fails++;
      end_sim();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // ready is sampled mid-cycle; inputs only move right after rising edges
  task automatic wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] resp);
    logic ah;
    logic wh;
    logic bh;
    bh = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!bh)
    begin
      @(negedge aclk);
      ah = awvalid && awready;
      wh = wvalid && wready;
      bh = bvalid;
      resp = bresp;
      clk_at_b = cpu_clk_en;
      @(posedge aclk);
      if (ah)
        awvalid <= 1'b0;
      if (wh)
        wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] resp);
    logic ah;
    logic rh;
    rh = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!rh)
    begin
      @(negedge aclk);
      ah = arvalid && arready;
      rh = rvalid;
      d = rdata;
      resp = rresp;
      @(posedge aclk);
      if (ah)
        arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask

  task automatic chk_state(input smc_state_t s);
    chk("power_state", 32'(s), 32'(power_state));
    chk("cpu_clk_en", 32'(s == SMC_RUN), {31'h0, cpu_clk_en});
    chk("periph_clk_en", 32'(s == SMC_RUN || s == SMC_LIGHT), {31'h0, periph_clk_en});
    chk("holds", (s == SMC_RUN) ? 32'h0 : 32'h3, {30'h0, fetch_hold, port_hold});
    chk("osc_enable", 32'(s != SMC_DEEP), {31'h0, osc_enable});
    chk("flash_ram", (s >= SMC_DEEP) ? 32'h3 : 32'h0, {30'h0, flash_stop, ram_retain});
  endtask

  // pulses live one cycle, so look just after each edge
  task automatic wait_for(input logic rst, output logic hit);
    hit = 1'b0;
    for (int i = 0; i < 80 && hit !== 1'b1; i++)
    begin
      @(posedge aclk);
      #1;
      hit = rst ? cpu_restart : wake_irq;
    end
  endtask

  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    rd(PC_A, d, r);
    chk("power_control_reset", {24'h0, `SMC_POWER_CONTROL_RST}, d);
    chk("power_control_rresp", {30'h0, `SMC_RESP_OKAY}, {30'h0, r});
    rd(12'h010, d, r);
    chk("unmapped_rresp", {30'h0, `SMC_RESP_SLVERR}, {30'h0, r});
    wr(12'h010, 8'h03, r);
    chk("unmapped_bresp", {30'h0, `SMC_RESP_SLVERR}, {30'h0, r});
    wr(ST_A, 8'h03, r);
    chk("status_bresp", {30'h0, `SMC_RESP_OKAY}, {30'h0, r});
    // byte lane 0 off: the request must not land
    wstrb <= 4'h0;
    wr(PC_A, 8'h01, r);
    wstrb <= 4'h1;
    rd(ST_A, d, r);
    chk("status_state", 32'h0, {30'h0, d[1:0]});
    #1;
    chk_state(SMC_RUN);
    $display("test regs done");
  endtask

  task automatic t_light();
    logic [31:0] d;
    logic [1:0] r;
    logic [7:0] frozen;
    logic hit;
    wr(PC_A, 8'h01, r);
    chk("cpu_clk_at_resp", 32'h0, {31'h0, clk_at_b});
    repeat (2) @(posedge aclk);
    #1;
    chk_state(SMC_LIGHT);
    frozen = pc;
    @(posedge aclk);
    irq_req <= 8'h40;
    repeat (8) @(posedge aclk);
    #1;
    chk_state(SMC_LIGHT);
    chk("pc_frozen", {24'h0, frozen}, {24'h0, pc});
    @(posedge aclk);
    irq_en <= 8'h40;
    wait_for(1'b0, hit);
    chk("wake_pulse", 32'h1, {31'h0, hit});
    chk("wake_id", 32'h6, {29'h0, wake_irq_id});
    chk("pc_resume", {24'h0, frozen}, {24'h0, pc});
    @(posedge aclk);
    irq_req <= 8'h00;
    rd(PC_A, d, r);
    chk("power_control_cleared", 32'h0, d);
    $display("test light done");
  endtask

  task automatic t_deep(input int id, input logic [7:0] v, input logic [3:0] dly);
    logic [31:0] d;
    logic [1:0] r;
    logic [7:0] frozen;
    logic hit;
    @(posedge aclk);
    osc_dly <= dly;
    irq_en <= 8'hff;
    wr(PC_A, v, r);
    repeat (6) @(posedge aclk);
    #1;
    chk_state(SMC_DEEP);
    frozen = pc;
    @(posedge aclk);
    irq_req <= 8'hc0;
    repeat (8) @(posedge aclk);
    #1;
    chk_state(SMC_DEEP);
    @(posedge aclk);
    irq_req <= 8'(1 << id);
    wait_for(1'b0, hit);
    chk("wake_pulse", 32'h1, {31'h0, hit});
    chk("osc_ready", 32'h1, {31'h0, osc_stable});
    chk("wake_id", 32'(id), {29'h0, wake_irq_id});
    chk("pc_resume", {24'h0, frozen}, {24'h0, pc});
    @(posedge aclk);
    irq_req <= 8'h00;
    rd(PC_A, d, r);
    chk("power_control_cleared", 32'h0, d);
    rd(ST_A, d, r);
    chk("status_id", 32'(id) << 4, d & 32'h1ff);
    repeat (4) @(posedge aclk);
    #1;
    chk_state(SMC_RUN);
    $display("test deep %0d done", id);
  endtask

  task automatic t_reset(input int ri);
    logic [31:0] d;
    logic [1:0] r;
    logic hit;
    wr(PC_A, (ri == 1 || ri == 2) ? 8'h02 : 8'h01, r);
    @(posedge aclk);
    // watchdog index 3 ends light sleep: software keeps it counting in sleep
    reset_src <= 4'(1 << ri);
    wait_for(1'b1, hit);
    chk("restart_pulse", 32'h1, {31'h0, hit});
    chk_state(SMC_RUN);
    @(posedge aclk);
    #1;
    chk("pc_restart", 32'h0, {24'h0, pc});
    @(posedge aclk);
    reset_src <= 4'h0;
    rd(ST_A, d, r);
    chk("status_by_reset", 32'h1, {31'h0, d[8]});
    $display("test reset %0d done", ri);
  endtask

  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_light();
    for (int i = 0; i < 6; i++)
      t_deep(i, i[0] ? 8'h03 : 8'h02, i[1] ? 4'd12 : 4'd1);
    for (int i = 0; i < 4; i++)
      t_reset(i);
    end_sim();
  end
endmodule
